//--- chip_select_option_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module chip_select_option_decode_tb;
    logic        i_clk_sys = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic        i_bus_read = 1'b1;
    logic        i_address_strobe_n = 1'b1;
    logic        i_ext_master = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [23:0] i_bus_addr = 24'h000000;
    logic [2:0]  i_bus_fc = 3'h6;
    logic [3:0]  p_lines = 4'h0;
    logic [3:0]  p_dly = 4'h0;
    wire  [15:0] o_reg_rdata;
    wire  [3:0]  o_select_n;
    wire         o_transfer_ack_n, o_transfer_ack_oe, o_cycle_end, o_bus_fault_n, p_ack_n;
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // wired-low ack pin: device drives only while enabled, peripheral pulls low
    wire ack_pin = (o_transfer_ack_oe ? o_transfer_ack_n : 1'b1) & p_ack_n;
    cs_top uut (.i_clk_sys, .i_reset_n, .i_clk_en(1'b1), .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_bus_addr, .i_bus_fc, .i_bus_read,
        .i_address_strobe_n, .i_ext_master, .i_transfer_ack_n(ack_pin), .o_select_n,
        .o_transfer_ack_n, .o_transfer_ack_oe, .o_cycle_end, .o_bus_fault_n);
    cs_periph u_per (.i_clk_sys, .i_select_n(o_select_n), .i_ext_lines(p_lines),
        .i_delay(p_dly), .o_ack_n(p_ack_n));
    initial
        forever #5 i_clk_sys = ~i_clk_sys;
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        begin
            tests_run++;
            if (g !== e)
            begin
                fails++;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        begin
            @(posedge i_clk_sys);
            i_reg_addr <= a;
            i_reg_wdata <= d;
            i_reg_wr <= 1'b1;
            @(posedge i_clk_sys);
            i_reg_wr <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        begin
            @(posedge i_clk_sys);
            i_reg_addr <= a;
            i_reg_rd <= 1'b1;
            @(posedge i_clk_sys);
            i_reg_rd <= 1'b0;
            #1;
            chk("rdata", e, o_reg_rdata);
        end
    endtask
    // one bus cycle: selects and fault seen at once, waits counted in edges
    task bus(input logic [23:0] a, input logic [2:0] fc, input logic r, x,
             input logic [3:0] s, w, input logic f);
        int n;
        begin
            @(posedge i_clk_sys);
            i_bus_addr <= a;
            i_bus_fc <= fc;
            i_bus_read <= r;
            i_ext_master <= x;
            i_address_strobe_n <= 1'b0;
            #1;
            chk("select", 16'(s), 16'(o_select_n));
            chk("fault", 16'(f), 16'(o_bus_fault_n));
            n = 0;
            if (s != 4'hf)
            begin
                while (!o_cycle_end && n < 20)
                begin
                    @(posedge i_clk_sys);
                    #1;
                    n++;
                end
                chk("waits", 16'(w), 16'(n));
            end
            @(posedge i_clk_sys);
            i_address_strobe_n <= 1'b1;
        end
    endtask
    // cut a hang short; the run needs well under a thousand cycles
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int k = 0; k < 4; k++)
            rd(8'(4 * k), 16'hdffd);
        rd(8'h30, 16'h0000);
        bus(24'h001ffe, 3'h6, 1, 0, 4'he, 6, 1);
        bus(24'h002000, 3'h6, 1, 0, 4'hf, 0, 1);
        bus(24'h000000, 3'h5, 1, 0, 4'hf, 0, 1);
        bus(24'h000000, 3'h6, 0, 0, 4'he, 6, 1);
        for (int k = 0; k < 7; k++)
        begin
            wr(8'h00, {3'(k), 13'h1ffc});
            bus(24'h000010, 3'h2, 1, 0, 4'he, 4'(k), 1);
        end
        bus(24'h000010, 3'h7, 1, 0, 4'hf, 0, 1);
        wr(8'h00, 16'h1ffc);
        wr(8'h20, 16'h0002);
        bus(24'h000010, 3'h1, 1, 1, 4'he, 1, 1);
        bus(24'h000010, 3'h1, 1, 0, 4'he, 0, 1);
        // line 1: 1M block at 0x200000 acked by the peripheral
        wr(8'h04, 16'hfe00);
        wr(8'h14, 16'h0401);
        p_lines <= 4'h2;
        for (int d = 0; d < 4; d += 3)
        begin
            p_dly <= 4'(d);
            bus(24'h2abcde, 3'h1, 1, 0, 4'hd, 4'(d), 1);
        end
        p_lines <= 4'h0;
        wr(8'h04, 16'h2e00);
        bus(24'ha00000, 3'h1, 1, 0, 4'hd, 1, 1);
        bus(24'h300000, 3'h1, 1, 0, 4'hf, 0, 1);
        wr(8'h04, 16'h2c02);
        wr(8'h20, 16'h0001);
        bus(24'h200000, 3'h1, 1, 0, 4'hd, 1, 1);
        bus(24'h200000, 3'h1, 0, 0, 4'hf, 0, 0);
        rd(8'h24, 16'h0001);
        wr(8'h24, 16'h0001);
        rd(8'h24, 16'h0000);
        wr(8'h14, 16'h0403);
        bus(24'h200000, 3'h1, 0, 0, 4'hd, 1, 1);
        bus(24'h200000, 3'h1, 1, 0, 4'hf, 0, 1);
        wr(8'h04, 16'h2c01);
        wr(8'h14, 16'ha401);
        bus(24'h200000, 3'h5, 1, 0, 4'hd, 1, 1);
        bus(24'h200000, 3'h4, 1, 0, 4'hf, 0, 1);
        wr(8'h14, 16'ha400);
        bus(24'h200000, 3'h5, 1, 0, 4'hf, 0, 1);
        tally_and_finish;
    end
endmodule
`default_nettype wire

//--- cs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// sees only the top ports; option words are shadowed from the register port
module cs_chk
(
    input wire logic        i_clk_sys,          // clock
    input wire logic        i_reset_n,          // sync reset, low
    input wire logic        i_clk_en,           // clock enable
    input wire logic [7:0]  i_reg_addr,         // register address
    input wire logic [15:0] i_reg_wdata,        // write data
    input wire logic        i_reg_wr,           // write strobe
    input wire logic        i_reg_rd,           // read strobe
    input wire logic [15:0] o_reg_rdata,        // read data
    input wire logic [2:0]  i_bus_fc,           // function code
    input wire logic        i_address_strobe_n, // strobe, low
    input wire logic        i_ext_master,       // outside master
    input wire logic        i_transfer_ack_n,   // ack pin in
    input wire logic [3:0]  o_select_n,         // selects, low
    input wire logic        o_transfer_ack_n,   // internal ack
    input wire logic        o_transfer_ack_oe,  // ack drive
    input wire logic        o_cycle_end         // cycle may end
);
    logic [15:0] opt [4];
    logic        xtra;
    logic [3:0]  cnt;
    logic [1:0]  idx;
    wire         sel    = !(&o_select_n);
    wire  [2:0]  code   = opt[idx][15:13];
    wire  [3:0]  need   = {1'b0, code} + {3'h0, i_ext_master & xtra};
    wire  [15:0] opt_rd = opt[i_reg_addr[3:2]];
    wire         opt_at = i_reg_addr[7:4] == 4'h0 && i_reg_addr[1:0] == 2'h0;
    // shadow words, so wait checks need no read-back from the design
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            opt  <= '{default: 16'hdffd};
            xtra <= 1'b0;
        end
        else if (i_reg_wr && i_clk_en && opt_at)
            opt[i_reg_addr[3:2]] <= i_reg_wdata;
        else if (i_reg_wr && i_clk_en && i_reg_addr == 8'h20)
            xtra <= i_reg_wdata[1];
    end
    // edges with strobe low; saturates so a long external wait never wraps
    always_ff @(posedge i_clk_sys)
        if (!i_reset_n || i_address_strobe_n)
            cnt <= 4'h0;
        else if (i_clk_en && cnt != 4'hf)
            cnt <= cnt + 4'h1;
    // asserted line with the highest priority
    always_comb
    begin
        idx = 2'h0;
        for (int k = 3; k >= 0; k--)
            if (!o_select_n[k])
                idx = 2'(k);
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_int_cycle;
        !i_address_strobe_n && sel && code != 3'h7;
    endsequence
    sequence s_ack_on;
        !o_transfer_ack_n && !i_address_strobe_n;
    endsequence
    a_fc_none_quiet: assert property (i_bus_fc == 3'h7 |-> &o_select_n)
        else $error("select with function code seven");
    a_ack_wait_count: assert property (s_int_cycle |-> o_transfer_ack_n == (cnt < need))
        else $error("internal ack at wrong wait count");
    a_int_drive_on: assert property (s_int_cycle |-> o_transfer_ack_oe)
        else $error("ack pin not driven for internal code");
    a_ext_no_drive: assert property ((!i_address_strobe_n && sel && code == 3'h7)
        |-> !o_transfer_ack_oe && o_cycle_end == !i_transfer_ack_n)
        else $error("external ack region handled wrongly");
    a_ack_needs_sel: assert property (!o_transfer_ack_n |-> sel)
        else $error("ack without a select");
    a_ack_hold: assert property (s_ack_on ##1 !i_address_strobe_n |-> !o_transfer_ack_n)
        else $error("ack dropped before strobe release");
    a_strobe_release: assert property (i_address_strobe_n
        |-> &o_select_n && o_transfer_ack_n && !o_transfer_ack_oe)
        else $error("select or ack without strobe");
    a_opt_readback: assert property ((i_reg_rd && i_clk_en && opt_at)
        |=> o_reg_rdata == $past(opt_rd))
        else $error("option word read back wrong");
    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0)
        else $error("read data outside read slot");
endmodule
bind cs_top cs_chk u_chk (.i_clk_sys, .i_reset_n, .i_clk_en, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_bus_fc, .i_address_strobe_n, .i_ext_master,
    .i_transfer_ack_n, .o_select_n, .o_transfer_ack_n, .o_transfer_ack_oe, .o_cycle_end);
`default_nettype wire

//--- cs_defs.vh
`ifndef CS_DEFS_VH
`define CS_DEFS_VH

// number of select lines and register port width
`define CS_LINES        4
`define CS_RADDR_W      8
`define CS_DATA_W       16

// register byte offsets, one aligned word each
`define CS_OFF_OPT0     8'h00
`define CS_OFF_BASE0    8'h10
`define CS_OFF_CTRL     8'h20
`define CS_OFF_STAT     8'h24
`define CS_OFF_STEP     8'h04

// option word fields
`define CS_OPT_ACK_HI   15
`define CS_OPT_ACK_LO   13
`define CS_OPT_MSK_HI   12
`define CS_OPT_MSK_LO   2
`define CS_OPT_DIRM     1
`define CS_OPT_SPACE    0

// base word fields
`define CS_BAS_FC_HI    15
`define CS_BAS_FC_LO    13
`define CS_BAS_ADR_HI   12
`define CS_BAS_ADR_LO   2
`define CS_BAS_RW       1
`define CS_BAS_EN       0

// control and status bits
`define CS_CTL_FAULT_ON 0
`define CS_CTL_EXTRA_WS 1
`define CS_STA_GUARD    0

// reset values
`define CS_OPT_RST      16'hdffd
`define CS_BAS0_RST     16'hc001
`define CS_BASN_RST     16'hc000
`define CS_CTL_RST      2'h0

// codes and counts
`define CS_ACK_EXT      3'h7
`define CS_FC_NONE      3'h7
`define CS_CNT_W        4
`define CS_CNT_MAX      4'hf

`endif

//--- cs_match.v
`timescale 1ns/1ps
`default_nettype none
`include "cs_defs.vh"

// address, direction and space compare for one select line
module cs_match
(
    input  wire [15:0] i_opt,     // option word
    input  wire [15:0] i_base,    // base word
    input  wire [10:0] i_addr,    // upper address lines
    input  wire [2:0]  i_fc,      // bus function code
    input  wire        i_read,    // 1 = read cycle
    output wire        o_hit,     // line may assert
    output wire        o_guard    // write to read-only region
);

    wire [10:0] mask;
    wire [10:0] base_adr;
    wire [2:0]  base_fc;
    wire        addr_ok;
    wire        fc_ok;
    wire        fc_none;
    wire        dir_ok;
    wire        pre_ok;
    wire        dirm;
    wire        base_rw;

    // field extraction
    assign mask     = i_opt[`CS_OPT_MSK_HI:`CS_OPT_MSK_LO];
    assign base_adr = i_base[`CS_BAS_ADR_HI:`CS_BAS_ADR_LO];
    assign base_fc  = i_base[`CS_BAS_FC_HI:`CS_BAS_FC_LO];
    assign dirm     = i_opt[`CS_OPT_DIRM];
    assign base_rw  = i_base[`CS_BAS_RW];

    // per-bit masking, so gaps in the mask give aliased blocks
    assign addr_ok = ((i_addr ^ base_adr) & mask) == 11'h000;

    // space compare only when enabled
    assign fc_ok = ~i_opt[`CS_OPT_SPACE] | (i_fc == base_fc);

    // code all ones never selects, compare or not
    assign fc_none = (i_fc == `CS_FC_NONE);

    // direction: rw bit 1 means write only
    assign dir_ok = ~dirm | (base_rw ? ~i_read : i_read);

    assign pre_ok = i_base[`CS_BAS_EN] & addr_ok & fc_ok & ~fc_none;

    assign o_hit   = pre_ok & dir_ok;
    assign o_guard = pre_ok & dirm & ~base_rw & ~i_read;

endmodule
`default_nettype wire

//--- cs_periph.sv
`timescale 1ns/1ps
`default_nettype none
// outside peripheral that acknowledges its own regions after a delay
module cs_periph
(
    input  wire logic       i_clk_sys,   // clock
    input  wire logic [3:0] i_select_n,  // select lines, low
    input  wire logic [3:0] i_ext_lines, // lines acked here
    input  wire logic [3:0] i_delay,     // waits before ack
    output var  logic       o_ack_n      // open-drain ack, low
);
    logic [3:0] cnt;
    wire        hit = |(~i_select_n & i_ext_lines); // never on internal regions
    // count waits while selected, so slow and prompt answers are both possible
    always @(posedge i_clk_sys)
        cnt <= !hit ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
    // released line floats to its pull-up
    assign o_ack_n = !(hit && cnt >= i_delay);
endmodule
`default_nettype wire

//--- cs_top.v
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cs_defs.vh"

// How it works
// - codes 0..6 give that many waits
// - all-ones code leaves acknowledge to peripheral
// - reset loads six waits in acknowledge field
// - waits counted on the system clock
// - zero waits acknowledges without a clock edge
// - cleared mask bit drops that address bit
// - reset sets all mask bits to one
// - direction mask limits line to one direction
// - direction mask clears on reset
// - space match compares programmed function code
// - space match sets on reset
// - function code all ones never selects
// - mask bits act individually, allowing aliases
// - option word field layout fixed
// - compare only upper address lines
// - disabled line never asserts
// - write to read-only flags, faults, no select
// - acknowledge only with an asserted select
module cs_top
(
    input  wire                   i_clk_sys,         // system clock
    input  wire                   i_reset_n,         // sync reset, low
    input  wire                   i_clk_en,          // freezes state when low
    input  wire [`CS_RADDR_W-1:0] i_reg_addr,        // register byte address
    input  wire [`CS_DATA_W-1:0]  i_reg_wdata,       // register write data
    input  wire                   i_reg_wr,          // write strobe
    input  wire                   i_reg_rd,          // read strobe
    output reg  [`CS_DATA_W-1:0]  o_reg_rdata,       // read data, next cycle
    input  wire [23:0]            i_bus_addr,        // bus address
    input  wire [2:0]             i_bus_fc,          // bus function code
    input  wire                   i_bus_read,        // 1 = read cycle
    input  wire                   i_address_strobe_n,// address strobe, low
    input  wire                   i_ext_master,      // cycle run by outside master
    input  wire                   i_transfer_ack_n,  // ack pin input, low
    output wire [`CS_LINES-1:0]   o_select_n,        // select lines, low
    output wire                   o_transfer_ack_n,  // ack pin output, low
    output wire                   o_transfer_ack_oe, // ack pin drive enable
    output wire                   o_cycle_end,       // cycle may terminate
    output wire                   o_bus_fault_n      // bus fault, low
);

    // option and base words, one per line; arrays keep the line index
    // a plain number inside the generate loop below
    reg  [15:0] opt_reg   [0:`CS_LINES-1];
    reg  [15:0] base_reg  [0:`CS_LINES-1];
    reg  [1:0]  ctrl_reg;
    reg  [1:0]  ctrl_next;
    reg         guard_flag_reg;
    reg         guard_flag_next;
    reg  [`CS_CNT_W-1:0] cnt_reg;
    reg  [`CS_CNT_W-1:0] cnt_next;
    reg  [`CS_DATA_W-1:0] rdata_next;

    wire [`CS_LINES-1:0] hit;
    wire [`CS_LINES-1:0] guard;
    wire [`CS_LINES-1:0] win;
    wire                 strobe_on;
    wire                 any_hit;
    wire                 guard_any;
    wire [2:0]           ack_code;
    wire                 ack_internal;
    wire [`CS_CNT_W-1:0] wait_cnt;
    wire                 wait_done;
    wire                 ack_int;
    wire                 fault_on;
    wire                 extra_ws;

    // offsets of lines 1 to 3, summed from 8-bit terms so the read mux
    // case items keep the width of the register address
    localparam [`CS_RADDR_W-1:0] OFF_OPT1  = `CS_OFF_OPT0 + `CS_OFF_STEP;
    localparam [`CS_RADDR_W-1:0] OFF_OPT2  = OFF_OPT1 + `CS_OFF_STEP;
    localparam [`CS_RADDR_W-1:0] OFF_OPT3  = OFF_OPT2 + `CS_OFF_STEP;
    localparam [`CS_RADDR_W-1:0] OFF_BASE1 = `CS_OFF_BASE0 + `CS_OFF_STEP;
    localparam [`CS_RADDR_W-1:0] OFF_BASE2 = OFF_BASE1 + `CS_OFF_STEP;
    localparam [`CS_RADDR_W-1:0] OFF_BASE3 = OFF_BASE2 + `CS_OFF_STEP;

    // true when the address hits one register word
    // full-width compare, so no word shows up at an alias offset
    function reg_at;
        input [`CS_RADDR_W-1:0] addr;
        input [`CS_RADDR_W-1:0] off;
        begin
            reg_at = (addr == off);
        end
    endfunction

    // lowest-numbered hit wins, the rest are suppressed
    // overlap is a software error; this keeps one select on the bus
    function [`CS_LINES-1:0] first_hit;
        input [`CS_LINES-1:0] h;
        integer k;
        reg     found;
        begin
            first_hit = {`CS_LINES{1'b0}};
            found     = 1'b0;
            for (k = 0; k < `CS_LINES; k = k + 1)
            begin
                if (h[k] && !found)
                begin
                    first_hit[k] = 1'b1;
                    found        = 1'b1;
                end
            end
        end
    endfunction

    assign strobe_on = ~i_address_strobe_n;
    assign fault_on  = ctrl_reg[`CS_CTL_FAULT_ON];
    assign extra_ws  = ctrl_reg[`CS_CTL_EXTRA_WS];

    // one compare unit and one pair of words per line
    genvar g;
    generate
        for (g = 0; g < `CS_LINES; g = g + 1)
        begin : g_line
            wire wr_opt;
            wire wr_base;

            // offsets worked out as integers, then cut to the address width
            localparam integer OPT_AT_I  = `CS_OFF_OPT0 + g * `CS_OFF_STEP;
            localparam integer BASE_AT_I = `CS_OFF_BASE0 + g * `CS_OFF_STEP;
            localparam [`CS_RADDR_W-1:0] OPT_AT  = OPT_AT_I[`CS_RADDR_W-1:0];
            localparam [`CS_RADDR_W-1:0] BASE_AT = BASE_AT_I[`CS_RADDR_W-1:0];

            assign wr_opt  = i_reg_wr & reg_at(i_reg_addr, OPT_AT);
            assign wr_base = i_reg_wr & reg_at(i_reg_addr, BASE_AT);

            // option word resets to six waits, full mask, space match on
            // a write in mid-cycle takes effect at once; reprogram idle lines
            always @(posedge i_clk_sys)
            begin
                if (!i_reset_n)
                begin
                    opt_reg[g] <= `CS_OPT_RST;
                end
                else if (i_clk_en && wr_opt)
                begin
                    opt_reg[g] <= i_reg_wdata;
                end
            end

            // only line 0 comes up enabled, for the boot memory
            // the enable bit lives here, so software writes this word after
            // the option word to avoid a half-programmed live line
            always @(posedge i_clk_sys)
            begin
                if (!i_reset_n)
                begin
                    base_reg[g] <= (g == 0) ? `CS_BAS0_RST : `CS_BASN_RST;
                end
                else if (i_clk_en && wr_base)
                begin
                    base_reg[g] <= i_reg_wdata;
                end
            end

            cs_match u_match
            (
                .i_opt   (opt_reg[g]),
                .i_base  (base_reg[g]),
                .i_addr  (i_bus_addr[23:13]),
                .i_fc    (i_bus_fc),
                .i_read  (i_bus_read),
                .o_hit   (hit[g]),
                .o_guard (guard[g])
            );
        end
    endgenerate

    // select decode is combinational so lines follow the strobe edge
    // outside masters see the lines a little later; that is covered by
    // the extra wait bit in software, nothing here slows the lines
    assign win        = first_hit(hit);
    assign any_hit    = |hit;
    assign o_select_n = ~(win & {`CS_LINES{strobe_on}});

    // acknowledge field of the winning line
    // with no hit the line 3 fallback is harmless: any_hit gates it below
    assign ack_code = win[0] ? opt_reg[0][`CS_OPT_ACK_HI:`CS_OPT_ACK_LO] :
                      win[1] ? opt_reg[1][`CS_OPT_ACK_HI:`CS_OPT_ACK_LO] :
                      win[2] ? opt_reg[2][`CS_OPT_ACK_HI:`CS_OPT_ACK_LO] :
                               opt_reg[3][`CS_OPT_ACK_HI:`CS_OPT_ACK_LO];

    // all-ones code hands the acknowledge to the peripheral
    // the peripheral then decides the cycle length on its own
    assign ack_internal = any_hit & (ack_code != `CS_ACK_EXT);

    // outside masters optionally get one more wait state
    // the extra wait adds to the target, so zero waits becomes one edge
    assign wait_cnt = {1'b0, ack_code} +
                      {{(`CS_CNT_W-1){1'b0}}, i_ext_master & extra_ws};

    // wait states counted in system clock edges after the strobe
    // asynchronous masters are timed on this clock too, never their own;
    // four bits hold the largest target of seven with room to saturate,
    // so a strobe held long after an internal ack never wraps back to a small count
    always @*
    begin
        cnt_next = cnt_reg;
        if (!strobe_on)
        begin
            cnt_next = {`CS_CNT_W{1'b0}};
        end
        else if (ack_internal && cnt_reg != `CS_CNT_MAX)
        begin
            cnt_next = cnt_reg + {{(`CS_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            cnt_reg <= {`CS_CNT_W{1'b0}};
        end
        else if (i_clk_en)
        begin
            cnt_reg <= cnt_next;
        end
    end

    // zero waits bypasses the counter, so no edge is needed
    // trade-off: that path is pure logic from the strobe, so its delay
    // follows the decode depth instead of a flop
    assign wait_done = (wait_cnt == {`CS_CNT_W{1'b0}}) |
                       (cnt_reg >= wait_cnt);

    // the counter saturates, so ack holds until the strobe drops
    // a strobe longer than fifteen edges still sees a steady ack
    assign ack_int = strobe_on & ack_internal & wait_done;

    assign o_transfer_ack_n  = ~ack_int;
    // driving only internal regions relies on peripherals keeping off
    // the pin is shared; oe high means this side pulls it, so an outside
    // driver on the same region would fight it
    assign o_transfer_ack_oe = strobe_on & ack_internal;

    // cycle ends on internal ack, or on the pin for external regions
    // the pin input is only trusted for lines coded for outside ack
    assign o_cycle_end = ack_int |
                         (strobe_on & any_hit & ~ack_internal &
                          ~i_transfer_ack_n);

    // a guarded write only counts when no other line takes it
    // the flag sets on every such cycle, the fault only with its enable;
    // the select stays high, so the write never reaches the memory
    assign guard_any     = strobe_on & (|guard) & ~any_hit;
    assign o_bus_fault_n = ~(guard_any & fault_on);

    // control word: fault enable and outside-master extra wait
    // a strobe during a freeze is lost, not queued for later
    always @*
    begin
        ctrl_next = ctrl_reg;
        if (i_reg_wr && reg_at(i_reg_addr, `CS_OFF_CTRL))
        begin
            ctrl_next = i_reg_wdata[1:0];
        end
    end

    always @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            ctrl_reg <= `CS_CTL_RST;
        end
        else if (i_clk_en)
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // sticky violation flag, write one clears, a new event wins
    // set wins so a violation in the clearing cycle is never lost
    always @*
    begin
        guard_flag_next = guard_flag_reg;
        if (i_reg_wr && reg_at(i_reg_addr, `CS_OFF_STAT) &&
            i_reg_wdata[`CS_STA_GUARD])
        begin
            guard_flag_next = 1'b0;
        end
        if (guard_any)
        begin
            guard_flag_next = 1'b1;
        end
    end

    always @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            guard_flag_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            guard_flag_reg <= guard_flag_next;
        end
    end

    // read mux; unmapped addresses read zero
    // reads have no side effects; the flag clears only by a write,
    // so a polling loop cannot lose an event
    always @*
    begin
        rdata_next = {`CS_DATA_W{1'b0}};
        case (i_reg_addr)
            `CS_OFF_OPT0:                  rdata_next = opt_reg[0];
            OFF_OPT1:                      rdata_next = opt_reg[1];
            OFF_OPT2:                      rdata_next = opt_reg[2];
            OFF_OPT3:                      rdata_next = opt_reg[3];
            `CS_OFF_BASE0:                 rdata_next = base_reg[0];
            OFF_BASE1:                     rdata_next = base_reg[1];
            OFF_BASE2:                     rdata_next = base_reg[2];
            OFF_BASE3:                     rdata_next = base_reg[3];
            `CS_OFF_CTRL:  rdata_next = {14'h0000, ctrl_reg};
            `CS_OFF_STAT:  rdata_next = {15'h0000, guard_flag_reg};
            default:       rdata_next = {`CS_DATA_W{1'b0}};
        endcase
    end

    // read data stands only in the cycle after the strobe
    // zero outside the slot keeps a stale word off a shared read path,
    // at the cost of one more gate in front of the output flops
    always @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_reg_rdata <= {`CS_DATA_W{1'b0}};
        end
        else if (i_clk_en)
        begin
            o_reg_rdata <= i_reg_rd ? rdata_next : {`CS_DATA_W{1'b0}};
        end
    end

endmodule
`default_nettype wire
